//--- rtl/lsr_pkg.sv
// Package for the loop 0 status readback bank: map, fields, carriers
package lsr_pkg;

  // Bus widths
  localparam int ADDR_W = 16; // Avalon byte address width
  localparam int DATA_W = 32; // Avalon data width
  localparam int IDX_W = 12; // Register index width
  localparam int IDX_LSB = 2; // Byte address = index * 4

  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_UPDATE = 12'h00F; // Register-update strobe
  localparam logic [IDX_W-1:0] IDX_LOCK = 12'hD20; // loop0_lock_flags
  localparam logic [IDX_W-1:0] IDX_STATE = 12'hD21; // loop0_state_flags
  localparam logic [IDX_W-1:0] IDX_LIMIT = 12'hD22; // loop0_limit_flags
  localparam logic [IDX_W-1:0] IDX_TW0 = 12'hD23; // holdover_word_byte0
  localparam logic [IDX_W-1:0] IDX_TW1 = 12'hD24; // holdover_word_byte1
  localparam logic [IDX_W-1:0] IDX_TW2 = 12'hD25; // holdover_word_byte2
  localparam logic [IDX_W-1:0] IDX_TW3 = 12'hD26; // holdover_word_byte3
  localparam logic [IDX_W-1:0] IDX_PBKT_LO = 12'hD27; // phase_bucket_low
  localparam logic [IDX_W-1:0] IDX_PBKT_HI = 12'hD28; // phase_bucket_high
  localparam logic [IDX_W-1:0] IDX_FBKT_LO = 12'hD29; // freq_bucket_low
  localparam logic [IDX_W-1:0] IDX_FBKT_HI = 12'hD2A; // freq_bucket_high
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'hD2C; // Sticky event status, W1C
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'hD2D; // Event mask, RW

  // Update command value
  localparam logic [7:0] UPDATE_CMD = 8'h01;

  // Lock register fields
  localparam int LOCK_CAL = 4; // Analog loop calibration running
  localparam int LOCK_ANA = 3; // Analog loop frequency lock
  localparam int LOCK_DFREQ = 2; // Digital loop frequency lock
  localparam int LOCK_DPHASE = 1; // Digital loop phase lock
  localparam int LOCK_ALL = 0; // All three loops locked

  // Loop-state register fields
  localparam int STATE_REF_LSB = 3; // Active reference, two bits
  localparam int STATE_SWITCH = 2; // Switching references
  localparam int STATE_HOLD = 1; // Holdover
  localparam int STATE_FREE = 0; // Free run

  // Limit-flags register fields
  localparam int LIM_DEMAP = 3; // Demapping controller clamped
  localparam int LIM_PSLEW = 2; // Phase slew limited
  localparam int LIM_FCLAMP = 1; // Frequency clamped
  localparam int LIM_HIST = 0; // Tuning word history available

  // Field widths
  localparam int TW_W = 30; // Holdover tuning word
  localparam int BKT_W = 12; // Lock detector bucket level

  // Event bits of the interrupt status and mask registers
  localparam int EV_N = 8;
  localparam int EV_HIST = 0; // History became available
  localparam int EV_HOLD = 1; // Entered holdover
  localparam int EV_FREE = 2; // Entered free run
  localparam int EV_SWITCH = 3; // Started reference switch
  localparam int EV_PLOSS = 4; // Lost digital phase lock
  localparam int EV_FLOSS = 5; // Lost digital frequency lock
  localparam int EV_CALEND = 6; // Analog calibration ended
  localparam int EV_ALLLOSS = 7; // All-locked dropped

  // Reset values
  localparam logic [EV_N-1:0] IRQ_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Active reference encoding
  typedef enum logic [1:0] {
    REF_INPUT_A = 2'b00,
    REF_INPUT_B = 2'b01,
    REF_INPUT_C = 2'b10,
    REF_INPUT_D = 2'b11
  } lsr_ref_e;

  // Bus handshake phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACK = 2'b10
  } lsr_phase_e;

  // Status of loop 0 as the loop logic reports it
  typedef struct packed {
    logic calBusy; // Analog loop calibration running
    logic anaLock; // Analog loop frequency locked
    logic dFreqLock; // Digital loop frequency locked
    logic dPhaseLock; // Digital loop phase locked
    logic sysLock; // System clock loop locked
    lsr_ref_e activeRef; // Reference in use by digital loop
    logic switching; // Digital loop switching references
    logic holdover; // Digital loop in holdover
    logic freeRun; // Digital loop in free run
    logic demapClamp; // Demapping controller clamped
    logic phaseSlew; // Phase slew limited
    logic freqClamp; // Frequency clamped
    logic histValid; // Tuning word history available
    logic [TW_W-1:0] tuneWord; // Averaged holdover tuning word
    logic [BKT_W-1:0] phaseBkt; // Phase lock bucket level
    logic [BKT_W-1:0] freqBkt; // Frequency lock bucket level
  } lsr_status_s;

  // Whole state of the bank
  typedef struct packed {
    lsr_phase_e phase; // Bus handshake phase
    logic waitReq; // Avalon waitrequest
    logic [DATA_W-1:0] readData; // Avalon readdata
    logic irqOut; // Interrupt level
    logic [EV_N-1:0] irqStat; // Sticky events
    logic [EV_N-1:0] irqMask; // Event enables
    lsr_status_s snap; // Snapshot shown to software
    lsr_status_s prevLive; // Last cycle's live status
  } lsr_state_s;

endpackage

//--- rtl/lsr_status_bank.sv
// Loop 0 read-only status bank with Avalon-MM slave and event interrupt
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module lsr_status_bank (
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [lsr_pkg::ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [lsr_pkg::DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [lsr_pkg::DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, low marks the answer
  output logic irq, // Level interrupt
  input wire lsr_pkg::lsr_status_s liveStatus // Loop status, same clock
);

  // Reset release synchroniser
  logic rstMeta_reg; // First stage, read only by second stage
  logic rstSync_reg; // Released reset used by the whole bank

  // State and its next value
  lsr_pkg::lsr_state_s st_reg;
  lsr_pkg::lsr_state_s st_next;

  // Decode helpers
  logic [lsr_pkg::IDX_W-1:0] idx; // Register index from address
  logic inRange; // Address bits above the index are clear
  logic [7:0] rdByte; // Byte presented by the addressed register
  logic [lsr_pkg::EV_N-1:0] evt; // Events seen this cycle
  logic [lsr_pkg::EV_N-1:0] clrBits; // W1C clear from software
  logic wrTake; // Write completes at this edge
  logic updHit; // Update strobe accepted at this edge
  logic allLockSnap; // Combined lock of the snapshot
  logic allLockLive; // Combined lock of live status
  logic allLockPrev; // Combined lock one cycle ago

  // Release reset through two flops so every flop leaves reset together
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // Address split; low two bits ignored as the word is always aligned
  assign idx = avs_address[lsr_pkg::IDX_LSB +: lsr_pkg::IDX_W];
  assign inRange = (avs_address[lsr_pkg::ADDR_W-1:lsr_pkg::IDX_LSB+lsr_pkg::IDX_W] == 2'h0);

  // All-locked needs system, analog and digital loops together
  assign allLockSnap = st_reg.snap.sysLock & st_reg.snap.anaLock
    & st_reg.snap.dPhaseLock;
  assign allLockLive = liveStatus.sysLock & liveStatus.anaLock & liveStatus.dPhaseLock;
  assign allLockPrev = st_reg.prevLive.sysLock & st_reg.prevLive.anaLock
    & st_reg.prevLive.dPhaseLock;

  // Read decode; reserved bits and unmapped indices read as zero
  always_comb begin
    rdByte = 8'h00;
    if (!inRange) begin
      rdByte = 8'h00;
    end else if (idx == lsr_pkg::IDX_LOCK) begin
      rdByte[lsr_pkg::LOCK_CAL] = st_reg.snap.calBusy;
      rdByte[lsr_pkg::LOCK_ANA] = st_reg.snap.anaLock;
      rdByte[lsr_pkg::LOCK_DFREQ] = st_reg.snap.dFreqLock;
      rdByte[lsr_pkg::LOCK_DPHASE] = st_reg.snap.dPhaseLock;
      rdByte[lsr_pkg::LOCK_ALL] = allLockSnap;
    end else if (idx == lsr_pkg::IDX_STATE) begin
      rdByte[lsr_pkg::STATE_REF_LSB +: 2] = st_reg.snap.activeRef;
      rdByte[lsr_pkg::STATE_SWITCH] = st_reg.snap.switching;
      rdByte[lsr_pkg::STATE_HOLD] = st_reg.snap.holdover;
      rdByte[lsr_pkg::STATE_FREE] = st_reg.snap.freeRun;
    end else if (idx == lsr_pkg::IDX_LIMIT) begin
      rdByte[lsr_pkg::LIM_DEMAP] = st_reg.snap.demapClamp;
      rdByte[lsr_pkg::LIM_PSLEW] = st_reg.snap.phaseSlew;
      rdByte[lsr_pkg::LIM_FCLAMP] = st_reg.snap.freqClamp;
      rdByte[lsr_pkg::LIM_HIST] = st_reg.snap.histValid;
    end else if (idx == lsr_pkg::IDX_TW0) begin
      // Averaged word only; no instantaneous path exists
      rdByte = st_reg.snap.tuneWord[7:0];
    end else if (idx == lsr_pkg::IDX_TW1) begin
      rdByte = st_reg.snap.tuneWord[15:8];
    end else if (idx == lsr_pkg::IDX_TW2) begin
      rdByte = st_reg.snap.tuneWord[23:16];
    end else if (idx == lsr_pkg::IDX_TW3) begin
      rdByte = {2'h0, st_reg.snap.tuneWord[29:24]};
    end else if (idx == lsr_pkg::IDX_PBKT_LO) begin
      rdByte = st_reg.snap.phaseBkt[7:0];
    end else if (idx == lsr_pkg::IDX_PBKT_HI) begin
      rdByte = {4'h0, st_reg.snap.phaseBkt[11:8]};
    end else if (idx == lsr_pkg::IDX_FBKT_LO) begin
      rdByte = st_reg.snap.freqBkt[7:0];
    end else if (idx == lsr_pkg::IDX_FBKT_HI) begin
      rdByte = {4'h0, st_reg.snap.freqBkt[11:8]};
    end else if (idx == lsr_pkg::IDX_IRQ_STAT) begin
      rdByte = st_reg.irqStat;
    end else if (idx == lsr_pkg::IDX_IRQ_MASK) begin
      rdByte = st_reg.irqMask;
    end else begin
      rdByte = 8'h00;
    end
  end

  // Write qualification: only the acknowledge cycle commits
  assign wrTake = (st_reg.phase == lsr_pkg::PH_ACK) && avs_write && inRange;
  assign updHit = wrTake && (idx == lsr_pkg::IDX_UPDATE) && avs_byteenable[0]
    && (avs_writedata[7:0] == lsr_pkg::UPDATE_CMD);
  assign clrBits = (wrTake && (idx == lsr_pkg::IDX_IRQ_STAT) && avs_byteenable[0])
    ? avs_writedata[lsr_pkg::EV_N-1:0] : 8'h00;

  // Event edges from live status; snapshot timing does not hide them
  always_comb begin
    evt = 8'h00;
    evt[lsr_pkg::EV_HIST] = liveStatus.histValid & ~st_reg.prevLive.histValid;
    evt[lsr_pkg::EV_HOLD] = liveStatus.holdover & ~st_reg.prevLive.holdover;
    evt[lsr_pkg::EV_FREE] = liveStatus.freeRun & ~st_reg.prevLive.freeRun;
    evt[lsr_pkg::EV_SWITCH] = liveStatus.switching & ~st_reg.prevLive.switching;
    evt[lsr_pkg::EV_PLOSS] = ~liveStatus.dPhaseLock & st_reg.prevLive.dPhaseLock;
    evt[lsr_pkg::EV_FLOSS] = ~liveStatus.dFreqLock & st_reg.prevLive.dFreqLock;
    evt[lsr_pkg::EV_CALEND] = ~liveStatus.calBusy & st_reg.prevLive.calBusy;
    evt[lsr_pkg::EV_ALLLOSS] = ~allLockLive & allLockPrev;
  end

  // Next-state logic: handshake, snapshot, events and interrupt
  always_comb begin
    st_next = st_reg;
    st_next.prevLive = liveStatus;
    case (st_reg.phase)
      lsr_pkg::PH_IDLE: begin
        // Take the request; answer one cycle later
        if (avs_read || avs_write) begin
          st_next.phase = lsr_pkg::PH_ACK;
          st_next.waitReq = 1'b0;
          st_next.readData = avs_read ? {24'h00_0000, rdByte} : lsr_pkg::RDATA_RST;
        end
      end
      lsr_pkg::PH_ACK: begin
        // Master samples waitrequest low here and drops the request
        st_next.phase = lsr_pkg::PH_IDLE;
        st_next.waitReq = 1'b1;
        // Status registers ignore writes; update and mask act here, the W1C status clear below
        if (updHit) begin
          st_next.snap = liveStatus;
        end
        if (wrTake && (idx == lsr_pkg::IDX_IRQ_MASK) && avs_byteenable[0]) begin
          st_next.irqMask = avs_writedata[lsr_pkg::EV_N-1:0];
        end
      end
      default: begin
        st_next.phase = lsr_pkg::PH_IDLE;
        st_next.waitReq = 1'b1;
      end
    endcase
    // A new event beats a clear in the same cycle
    st_next.irqStat = (st_reg.irqStat & ~clrBits) | evt;
    st_next.irqOut = |(st_next.irqStat & st_next.irqMask);
  end

  // State register
  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      st_reg <= '0;
      st_reg.phase <= lsr_pkg::PH_IDLE;
      st_reg.waitReq <= 1'b1;
      st_reg.irqMask <= lsr_pkg::IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = st_reg.readData;
  assign avs_waitrequest = st_reg.waitReq;
  assign irq = st_reg.irqOut;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_reg);

  // Read launched in the idle phase
  logic rdStart;
  assign rdStart = (st_reg.phase == lsr_pkg::PH_IDLE) && avs_read && inRange;

  update_snap_a: assert property (updHit |=> st_reg.snap == $past(liveStatus))
    else $error("Update strobe did not capture live status");

  cal_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LOCK |=> !avs_waitrequest
      && avs_readdata[lsr_pkg::LOCK_CAL] == $past(st_reg.snap.calBusy))
    else $error("Calibration bit wrong on read");

  ana_lock_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LOCK
      |=> avs_readdata[lsr_pkg::LOCK_ANA] == $past(st_reg.snap.anaLock))
    else $error("Analog lock bit wrong on read");

  dig_lock_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LOCK
      |=> avs_readdata[lsr_pkg::LOCK_DFREQ] == $past(st_reg.snap.dFreqLock)
      && avs_readdata[lsr_pkg::LOCK_DPHASE] == $past(st_reg.snap.dPhaseLock))
    else $error("Digital lock bits wrong on read");

  all_lock_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LOCK
      |=> avs_readdata[lsr_pkg::LOCK_ALL] == $past(allLockSnap)
      && avs_readdata[7:5] == 3'h0)
    else $error("All-locked bit wrong on read");

  ref_field_a: assert property (
    rdStart && idx == lsr_pkg::IDX_STATE
      |=> avs_readdata[4:3] == $past(st_reg.snap.activeRef)
      && avs_readdata[1] == $past(st_reg.snap.holdover))
    else $error("Reference or holdover field wrong");

  hist_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LIMIT
      |=> avs_readdata[3:0] == $past({st_reg.snap.demapClamp, st_reg.snap.phaseSlew,
        st_reg.snap.freqClamp, st_reg.snap.histValid}))
    else $error("Limit flags wrong on read");

  word_top_a: assert property (
    rdStart && idx == lsr_pkg::IDX_TW3
      |=> avs_readdata[7:6] == 2'h0 && avs_readdata[5:0] == $past(st_reg.snap.tuneWord[29:24]))
    else $error("Tuning word top byte wrong");

  bucket_hi_a: assert property (
    rdStart && idx == lsr_pkg::IDX_FBKT_HI
      |=> avs_readdata[31:4] == 28'h000_0000
      && avs_readdata[3:0] == $past(st_reg.snap.freqBkt[11:8]))
    else $error("Frequency bucket high byte wrong");

  ro_write_a: assert property (
    wrTake && idx != lsr_pkg::IDX_UPDATE |=> $stable(st_reg.snap))
    else $error("Write changed read-only status");

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
      |-> !avs_waitrequest)
    else $error("Request not answered in one cycle");

  // Each bank bit is checked against the snapshot, never live status
  phase_lock_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LOCK
      |=> avs_readdata[lsr_pkg::LOCK_DPHASE] == $past(st_reg.snap.dPhaseLock))
    else $error("Phase lock bit wrong on read");

  // Loop-state fields
  switch_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_STATE
      |=> avs_readdata[lsr_pkg::STATE_SWITCH] == $past(st_reg.snap.switching))
    else $error("Switching bit wrong on read");

  hold_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_STATE
      |=> avs_readdata[lsr_pkg::STATE_HOLD] == $past(st_reg.snap.holdover))
    else $error("Holdover bit wrong on read");

  free_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_STATE
      |=> avs_readdata[lsr_pkg::STATE_FREE] == $past(st_reg.snap.freeRun)
      && avs_readdata[7:5] == 3'h0)
    else $error("Free run bit wrong on read");

  // Limit flags, one bit each
  demap_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LIMIT
      |=> avs_readdata[lsr_pkg::LIM_DEMAP] == $past(st_reg.snap.demapClamp))
    else $error("Demapper clamp bit wrong on read");

  slew_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LIMIT
      |=> avs_readdata[lsr_pkg::LIM_PSLEW] == $past(st_reg.snap.phaseSlew))
    else $error("Phase slew bit wrong on read");

  clamp_bit_a: assert property (
    rdStart && idx == lsr_pkg::IDX_LIMIT
      |=> avs_readdata[lsr_pkg::LIM_FCLAMP] == $past(st_reg.snap.freqClamp)
      && avs_readdata[7:4] == 4'h0)
    else $error("Frequency clamp bit wrong on read");

  // Tuning word bytes, least significant first
  word_low_a: assert property (
    rdStart && idx == lsr_pkg::IDX_TW0
      |=> avs_readdata[7:0] == $past(st_reg.snap.tuneWord[7:0]))
    else $error("Tuning word low byte wrong");

  // Middle bytes must come from the same snapshot as the ends
  word_mid_a: assert property (
    rdStart && (idx == lsr_pkg::IDX_TW1 || idx == lsr_pkg::IDX_TW2)
      |=> avs_readdata[7:0] == $past(idx == lsr_pkg::IDX_TW1
        ? st_reg.snap.tuneWord[15:8] : st_reg.snap.tuneWord[23:16]))
    else $error("Tuning word middle byte wrong");

  // Bucket levels are twelve bits split over two registers
  pbkt_low_a: assert property (
    rdStart && idx == lsr_pkg::IDX_PBKT_LO
      |=> avs_readdata[7:0] == $past(st_reg.snap.phaseBkt[7:0]))
    else $error("Phase bucket low byte wrong");

  pbkt_high_a: assert property (
    rdStart && idx == lsr_pkg::IDX_PBKT_HI
      |=> avs_readdata[7:4] == 4'h0
      && avs_readdata[3:0] == $past(st_reg.snap.phaseBkt[11:8]))
    else $error("Phase bucket high byte wrong");

  fbkt_low_a: assert property (
    rdStart && idx == lsr_pkg::IDX_FBKT_LO
      |=> avs_readdata[7:0] == $past(st_reg.snap.freqBkt[7:0]))
    else $error("Frequency bucket low byte wrong");

  // Bus behaviour
  update_reads_zero_a: assert property (
    rdStart && idx == lsr_pkg::IDX_UPDATE |=> avs_readdata == lsr_pkg::RDATA_RST)
    else $error("Update register did not read zero");

  upper_zero_a: assert property (
    !avs_waitrequest |-> avs_readdata[lsr_pkg::DATA_W-1:8] == 24'h00_0000)
    else $error("Unused read lanes not zero");

  // Low for one cycle only, so a held request is never taken twice
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle");

  // Interrupt status and mask; a new event must survive a same-cycle clear
  set_wins_a: assert property (|evt |=> (st_reg.irqStat & $past(evt)) == $past(evt))
    else $error("Event lost from sticky status");

  // A one written clears only bits with no event in that cycle
  clear_done_a: assert property (
    |(clrBits & ~evt) |=> (st_reg.irqStat & $past(clrBits & ~evt)) == 8'h00)
    else $error("Sticky status not cleared by write");

  // Mask takes the written byte at the acknowledge edge
  mask_write_a: assert property (
    wrTake && idx == lsr_pkg::IDX_IRQ_MASK && avs_byteenable[0]
      |=> st_reg.irqMask == $past(avs_writedata[lsr_pkg::EV_N-1:0]))
    else $error("Mask write not applied");

  // Main scenarios
  upd_then_read_c: cover property (updHit ##[1:8] rdStart && idx == lsr_pkg::IDX_LOCK);
  irq_raise_c: cover property (!irq ##1 irq);
  clear_race_c: cover property (|(clrBits & evt));
  hold_read_c: cover property (rdStart && idx == lsr_pkg::IDX_TW0 && st_reg.snap.histValid);
  mask_block_c: cover property (|(st_reg.irqStat & ~st_reg.irqMask) && !irq);

endmodule

`default_nettype wire

//--- test/test_lsr_status_bank.sv
// Self-checking bench for the loop 0 status readback bank
`timescale 1ns/10ps
`default_nettype none

// Compare one value, count it, report a mismatch at once
`define CHECK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", what, exp, got); end end

module test_lsr_status_bank;
  logic clk; // Bench clock
  logic nrst; // Reset, active low
  logic [lsr_pkg::ADDR_W-1:0] avs_address; // Byte address
  logic avs_read; // Read request
  logic avs_write; // Write request
  logic [lsr_pkg::DATA_W-1:0] avs_writedata; // Write data
  logic [3:0] avs_byteenable; // Byte lanes
  logic [lsr_pkg::DATA_W-1:0] avs_readdata; // Read data
  logic avs_waitrequest; // Slave stall
  logic irq; // Interrupt level
  lsr_pkg::lsr_status_s liveStatus; // Loop status driven by the bench
  lsr_pkg::lsr_status_s pat; // Pattern under test
  lsr_pkg::lsr_status_s held; // Pattern last latched by an update
  logic [31:0] rdata; // Last read result
  int miscompares; // Mismatch count
  int nChecks; // Comparison count

  lsr_status_bank lsr_status_bank_i (
    .clk(clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .liveStatus(liveStatus)
  );

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One Avalon transfer; held until a rising edge samples waitrequest low
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    avs_address <= {2'b00, idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    // Data taken at the very edge that sees waitrequest low, then released
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      miscompares++;
      $display("FAIL waitrequest expected 0 seen %b", avs_waitrequest);
    end
  endtask

  // Expected byte of a bank register, from the field layout
  function automatic logic [7:0] expReg(lsr_pkg::lsr_status_s s, logic [11:0] idx);
    case (idx)
      12'hD20: return {3'b000, s.calBusy, s.anaLock, s.dFreqLock, s.dPhaseLock,
                       s.sysLock & s.anaLock & s.dPhaseLock};
      12'hD21: return {3'b000, s.activeRef, s.switching, s.holdover, s.freeRun};
      12'hD22: return {4'h0, s.demapClamp, s.phaseSlew, s.freqClamp, s.histValid};
      12'hD23: return s.tuneWord[7:0];
      12'hD24: return s.tuneWord[15:8];
      12'hD25: return s.tuneWord[23:16];
      12'hD26: return {2'b00, s.tuneWord[29:24]};
      12'hD27: return s.phaseBkt[7:0];
      12'hD28: return {4'h0, s.phaseBkt[11:8]};
      12'hD29: return s.freqBkt[7:0];
      12'hD2A: return {4'h0, s.freqBkt[11:8]};
      default: return 8'h00;
    endcase
  endfunction

  // Distinct patterns; k = 1, 2, 3 each drop one loop of the all-locked set
  function automatic lsr_pkg::lsr_status_s mkPat(int k);
    lsr_pkg::lsr_status_s s;
    s = '0;
    s.calBusy = k[0];
    s.anaLock = (k != 1);
    s.dFreqLock = k[1];
    s.dPhaseLock = (k != 2);
    s.sysLock = (k != 3);
    s.activeRef = lsr_pkg::lsr_ref_e'(k[1:0]);
    s.switching = k[2];
    s.holdover = k[0] ^ k[2];
    s.freeRun = k[1] ^ k[2];
    s.demapClamp = k[0];
    s.phaseSlew = k[1];
    s.freqClamp = k[2];
    s.histValid = ~k[0];
    s.tuneWord = 30'h3FFFFFFF ^ (30'h01234567 << k);
    s.phaseBkt = 12'hFFF >> k;
    s.freqBkt = 12'hA5C ^ 12'(k * 12'h111);
    return s;
  endfunction

  // Read every bank register and the gap after it
  task automatic checkBank(lsr_pkg::lsr_status_s s);
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 12'hD20 + 12'(i), 8'h00);
      `CHECK("bank byte", {24'h000000, expReg(s, 12'hD20 + 12'(i))}, rdata)
    end
  endtask

  // Verdict, printed once from here
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    miscompares++;
    $display("FAIL watchdog expected done seen hang");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    liveStatus = '0;
    miscompares = 0;
    nChecks = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values of the mask register and the irq output
    bus(1'b0, lsr_pkg::IDX_IRQ_MASK, 8'h00);
    `CHECK("mask reset", 32'h00000000, rdata)
    `CHECK("irq reset", 1'b0, irq)
    $display("Test reset done");
    // Field layout over all patterns, every reference code
    for (int k = 0; k < 8; k++) begin
      pat = mkPat(k);
      liveStatus <= pat;
      bus(1'b1, lsr_pkg::IDX_UPDATE, 8'h01);
      checkBank(pat);
    end
    held = pat;
    $display("Test fields done");
    // Live changes stay hidden until a proper update
    pat = mkPat(2);
    liveStatus <= pat;
    checkBank(held);
    bus(1'b1, lsr_pkg::IDX_UPDATE, 8'h02);
    checkBank(held);
    bus(1'b1, lsr_pkg::IDX_LOCK, 8'hFF);
    bus(1'b1, lsr_pkg::IDX_TW3, 8'hFF);
    checkBank(held);
    // Update with the low byte lane disabled must be ignored
    avs_byteenable <= 4'hE;
    bus(1'b1, lsr_pkg::IDX_UPDATE, 8'h01);
    avs_byteenable <= 4'hF;
    checkBank(held);
    bus(1'b1, lsr_pkg::IDX_UPDATE, 8'h01);
    checkBank(pat);
    bus(1'b0, lsr_pkg::IDX_UPDATE, 8'h00);
    `CHECK("update readback", 32'h00000000, rdata)
    $display("Test snapshot done");
    // Interrupt: raise, mask, clear
    pat = mkPat(0);
    liveStatus <= pat;
    repeat (3) @(posedge clk);
    bus(1'b1, lsr_pkg::IDX_IRQ_STAT, 8'hFF);
    bus(1'b1, lsr_pkg::IDX_IRQ_MASK, 8'h02);
    pat.holdover = 1'b1;
    liveStatus <= pat;
    repeat (3) @(negedge clk);
    `CHECK("irq on hold", 1'b1, irq)
    bus(1'b0, lsr_pkg::IDX_IRQ_STAT, 8'h00);
    `CHECK("stat hold", 32'h00000002, rdata)
    bus(1'b1, lsr_pkg::IDX_IRQ_STAT, 8'h02);
    repeat (2) @(negedge clk);
    `CHECK("irq cleared", 1'b0, irq)
    @(posedge clk);
    pat.freeRun = 1'b1;
    liveStatus <= pat;
    repeat (3) @(negedge clk);
    `CHECK("irq masked", 1'b0, irq)
    bus(1'b1, lsr_pkg::IDX_IRQ_MASK, 8'h04);
    repeat (2) @(negedge clk);
    `CHECK("irq unmasked", 1'b1, irq)
    bus(1'b0, lsr_pkg::IDX_IRQ_MASK, 8'h00);
    `CHECK("mask value", 32'h00000004, rdata)
    bus(1'b1, lsr_pkg::IDX_IRQ_STAT, 8'h04);
    repeat (2) @(negedge clk);
    `CHECK("irq final", 1'b0, irq)
    $display("Test interrupt done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
